// >>> verilog/timer8_defs.svh
// Register map, field positions, reset values and mode codes of the timer.
// Assumes inclusion by bare name from the design file.
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH
`define OFS_CTRL_A     8'h00
`define OFS_CTRL_B     8'h04
`define OFS_CTRL_C     8'h08
`define OFS_COUNT      8'h0c
`define OFS_CMP_A      8'h10
`define OFS_CMP_B      8'h14
`define OFS_MASK       8'h18
`define OFS_FLAG       8'h1c
`define BIT_OVF        0
`define BIT_CMP_A      1
`define BIT_CMP_B      2
`define BIT_FORCE_A    7
`define BIT_FORCE_B    6
`define BIT_WGM_HIGH   3
`define CNT_BOTTOM     8'h00
`define CNT_MAX        8'hff
`define RST_BYTE       8'h00
`define CS_STOP        3'h0
`define CS_DIV1        3'h1
`define CS_DIV8        3'h2
`define CS_DIV64       3'h3
`define CS_DIV256      3'h4
`define CS_DIV1024     3'h5
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7
`define PRE_MASK_8     10'h007
`define PRE_MASK_64    10'h03f
`define PRE_MASK_256   10'h0ff
`define PRE_MASK_1024  10'h3ff
`define COM_NONE       2'h0
`define COM_TOGGLE     2'h1
`define COM_CLEAR      2'h2
`define COM_SET        2'h3
`endif

// >>> verilog/timer8_pkg.sv
// Types shared by the timer: waveform modes and the per-unit control carrier.
// Assumes the defines header sits in the include path.
`default_nettype none
package timer8_pkg;
    typedef enum logic [2:0] {
        WM_NORMAL    = 3'b000,
        WM_PHASE_MAX = 3'b001,
        WM_CTC       = 3'b010,
        WM_FAST_MAX  = 3'b011,
        WM_RSVD_4    = 3'b100,
        WM_PHASE_A   = 3'b101,
        WM_RSVD_6    = 3'b110,
        WM_FAST_A    = 3'b111
    } wave_mode_t;

    typedef struct packed {
        logic [1:0] compare_output_mode;
        logic       pwm;
        logic       fast;
        logic       up;
    } unit_ctl_t;
endpackage : timer8_pkg
`default_nettype wire

// >>> verilog/timer8_dual_compare_pwm.sv
// 8-bit timer/counter with two compare units, waveform outputs and APB registers.
// Assumes one 20 MHz clock; the external count pin is asynchronous to it.
`default_nettype none
`include "timer8_defs.svh"

// ============================================================
// Compare unit
module timer8_compare_unit (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire timer8_pkg::unit_ctl_t i_ctl,
    input  wire logic [7:0]           i_count,
    input  wire logic [7:0]           i_wr_data,
    input  wire logic                 i_wr,
    input  wire logic                 i_load,
    input  wire logic                 i_tick,
    input  wire logic                 i_block,
    input  wire logic                 i_bottom_evt,
    input  wire logic                 i_force,
    input  wire logic                 i_clear,
    output logic [7:0]                o_active,
    output logic [7:0]                o_buffer,
    output logic                      o_match,
    output logic                      o_flag,
    output logic                      o_wave
);
    logic hit;
    logic act;
    logic wave_next;

    assign o_match = (i_count == o_active);
    assign hit     = i_tick && o_match && !i_block;
    assign act     = hit || i_force;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_buffer <= `RST_BYTE;
        end else if (i_wr) begin
            o_buffer <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_active <= `RST_BYTE;
        end else if (i_wr && !i_ctl.pwm) begin
            o_active <= i_wr_data;
        end else if (i_load && i_ctl.pwm) begin
            o_active <= o_buffer;
        end
    end

    // flag on tick after match; set beats clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flag <= 1'b0;
        end else if (hit) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end

    // waveform action; output mode used live; mode zero idle
    always_comb begin
        wave_next = o_wave;
        if (!i_ctl.pwm) begin
            if (act) begin
                unique case (i_ctl.compare_output_mode)
                    `COM_NONE:   wave_next = o_wave;
                    `COM_TOGGLE: wave_next = !o_wave;
                    `COM_CLEAR:  wave_next = 1'b0;
                    `COM_SET:    wave_next = 1'b1;
                endcase
            end
        end else if (i_ctl.compare_output_mode[1]) begin
            if (hit) begin
                wave_next = i_ctl.compare_output_mode[0] ^ (!i_ctl.fast && !i_ctl.up);
            end else if (i_ctl.fast && i_bottom_evt) begin
                wave_next = !i_ctl.compare_output_mode[0];
            end
        end
    end

    // state register not reset by mode changes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wave <= 1'b0;
        end else begin
            o_wave <= wave_next;
        end
    end
endmodule : timer8_compare_unit

// ============================================================
// Top: APB slave, clock select, counter
module timer8_dual_compare_pwm (
    input  wire logic        I_MCLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_EXT_COUNT_INPUT,
    input  wire logic        I_ACK_OVF,
    input  wire logic        I_ACK_CMP_A,
    input  wire logic        I_ACK_CMP_B,
    output logic             O_IRQ_OVF,
    output logic             O_IRQ_CMP_A,
    output logic             O_IRQ_CMP_B,
    output logic             O_WAVE_OUT_A,
    output logic             O_WAVE_OUT_B,
    output logic             O_WAVE_EN_A,
    output logic             O_WAVE_EN_B
);
    logic [7:0]             control_a_reg;
    logic [7:0]             control_b_reg;
    logic [7:0]             count_value_reg;
    logic [2:0]             mask_reg;
    logic                   overflow_flag_reg;
    logic                   up_reg;
    logic                   block_reg;
    logic [9:0]             presc_reg;
    logic                   ext_meta_reg;
    logic                   ext_sync_reg;
    logic                   ext_prev_reg;
    logic                   timer_tick;
    logic [2:0]             clock_select;
    timer8_pkg::wave_mode_t waveform_mode;
    logic                   pwm;
    logic                   fast;
    logic                   phase;
    logic                   top_is_a;
    logic [7:0]             top_val;
    logic                   at_top;
    logic                   at_bottom;
    logic                   at_max;
    logic                   wr_en;
    logic                   cnt_wr;
    logic [7:0]             wdat;
    logic [31:0]            rd_data;
    logic                   addr_ok;
    logic                   force_a;
    logic                   force_b;
    logic                   load_evt;
    logic                   bottom_evt;
    logic [7:0]             active_a;
    logic [7:0]             active_b;
    logic [7:0]             buffer_a;
    logic [7:0]             buffer_b;
    logic                   match_a;
    logic                   match_b;
    logic                   compare_a_flag;
    logic                   compare_b_flag;
    logic                   wave_a;
    logic                   wave_b;
    timer8_pkg::unit_ctl_t  ctl_a;
    timer8_pkg::unit_ctl_t  ctl_b;

    // ========================================================
    // APB access
    assign wr_en  = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
    assign wdat   = I_PWDATA[7:0];
    assign cnt_wr = wr_en && (I_PADDR == `OFS_COUNT);

    always_comb begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (I_PADDR)
            `OFS_CTRL_A: rd_data[7:0] = control_a_reg;
            `OFS_CTRL_B: rd_data[7:0] = control_b_reg;
            `OFS_CTRL_C: rd_data[7:0] = `RST_BYTE;
            `OFS_COUNT:  rd_data[7:0] = count_value_reg;
            `OFS_CMP_A:  rd_data[7:0] = buffer_a;
            `OFS_CMP_B:  rd_data[7:0] = buffer_b;
            `OFS_MASK:   rd_data[2:0] = mask_reg;
            `OFS_FLAG:   rd_data[2:0] = {compare_b_flag, compare_a_flag, overflow_flag_reg};
            default:     addr_ok = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so the access phase ends at once.
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
        end else begin
            O_PREADY  <= I_PSEL && !I_PENABLE;
            O_PSLVERR <= I_PSEL && !I_PENABLE && !addr_ok;
            O_PRDATA  <= (I_PSEL && !I_PENABLE && !I_PWRITE) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            control_a_reg <= `RST_BYTE;
            control_b_reg <= `RST_BYTE;
            mask_reg      <= 3'h0;
        end else if (wr_en) begin
            if (I_PADDR == `OFS_CTRL_A) begin
                control_a_reg <= wdat;
            end
            if (I_PADDR == `OFS_CTRL_B) begin
                control_b_reg <= {4'h0, wdat[3:0]};
            end
            if (I_PADDR == `OFS_MASK) begin
                mask_reg <= wdat[2:0];
            end
        end
    end

    // force only outside PWM; one-cycle strobe
    assign force_a = wr_en && (I_PADDR == `OFS_CTRL_C) && wdat[`BIT_FORCE_A] && !pwm;
    assign force_b = wr_en && (I_PADDR == `OFS_CTRL_C) && wdat[`BIT_FORCE_B] && !pwm;

    // ========================================================
    // Mode decode
    // mode bits split across controls
    assign waveform_mode = timer8_pkg::wave_mode_t'({control_b_reg[`BIT_WGM_HIGH],
                                                     control_a_reg[1:0]});
    assign clock_select  = control_b_reg[2:0];
    assign pwm      = waveform_mode[0];
    assign fast     = (waveform_mode == timer8_pkg::WM_FAST_MAX)
                   || (waveform_mode == timer8_pkg::WM_FAST_A);
    assign phase    = pwm && !fast;
    assign top_is_a = (waveform_mode == timer8_pkg::WM_CTC)
                   || (waveform_mode == timer8_pkg::WM_PHASE_A)
                   || (waveform_mode == timer8_pkg::WM_FAST_A);
    assign top_val  = top_is_a ? active_a : `CNT_MAX;
    assign at_top   = (count_value_reg == top_val);
    assign at_bottom = (count_value_reg == `CNT_BOTTOM);
    assign at_max    = (count_value_reg == `CNT_MAX);

    // ========================================================
    // Clock select
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            presc_reg    <= 10'h000;
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            presc_reg    <= presc_reg + 10'h001;
            ext_meta_reg <= I_EXT_COUNT_INPUT;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    // source and edge; stop at zero
    always_comb begin
        unique case (clock_select)
            `CS_STOP:     timer_tick = 1'b0;
            `CS_DIV1:     timer_tick = 1'b1;
            `CS_DIV8:     timer_tick = (presc_reg & `PRE_MASK_8) == `PRE_MASK_8;
            `CS_DIV64:    timer_tick = (presc_reg & `PRE_MASK_64) == `PRE_MASK_64;
            `CS_DIV256:   timer_tick = (presc_reg & `PRE_MASK_256) == `PRE_MASK_256;
            `CS_DIV1024:  timer_tick = (presc_reg & `PRE_MASK_1024) == `PRE_MASK_1024;
            `CS_EXT_FALL: timer_tick = ext_prev_reg && !ext_sync_reg;
            `CS_EXT_RISE: timer_tick = !ext_prev_reg && ext_sync_reg;
        endcase
    end

    // ========================================================
    // Counter
    // write beats count; clear, up or down
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            count_value_reg <= `CNT_BOTTOM;
            up_reg          <= 1'b1;
        end else if (cnt_wr) begin
            count_value_reg <= wdat;
        end else if (timer_tick) begin
            if (!phase) begin
                up_reg <= 1'b1;
                // clear on compare A; wraps in normal mode
                count_value_reg <= (top_is_a && at_top) || (fast && at_top)
                                 ? `CNT_BOTTOM : count_value_reg + 8'h01;
            end else if (up_reg && at_top) begin
                up_reg          <= 1'b0;
                count_value_reg <= count_value_reg - 8'h01;
            end else if (!up_reg && at_bottom) begin
                up_reg          <= 1'b1;
                count_value_reg <= count_value_reg + 8'h01;
            end else begin
                count_value_reg <= up_reg ? count_value_reg + 8'h01
                                          : count_value_reg - 8'h01;
            end
        end
    end

    // block lasts until the next tick
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            block_reg <= 1'b0;
        end else if (cnt_wr) begin
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    // overflow point by mode; set beats clear
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            overflow_flag_reg <= 1'b0;
        end else if (timer_tick && !cnt_wr && ((!pwm && at_max) || (fast && at_top)
                                            || (phase && !up_reg && at_bottom))) begin
            overflow_flag_reg <= 1'b1;
        end else if (I_ACK_OVF || (wr_en && (I_PADDR == `OFS_FLAG) && wdat[`BIT_OVF])) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // ========================================================
    // Compare units
    // load at top of sequence
    assign load_evt   = timer_tick && !cnt_wr && at_top && up_reg;
    assign bottom_evt = timer_tick && !cnt_wr && fast && at_top;
    assign ctl_a = '{compare_output_mode: control_a_reg[7:6], pwm: pwm, fast: fast,
                     up: up_reg};
    assign ctl_b = '{compare_output_mode: control_a_reg[5:4], pwm: pwm, fast: fast,
                     up: up_reg};

    // clear by service or write one
    timer8_compare_unit u_cmp_a (
        .i_clk        (I_MCLK),
        .i_rst_n      (I_RSTN),
        .i_ctl        (ctl_a),
        .i_count      (count_value_reg),
        .i_wr_data    (wdat),
        .i_wr         (wr_en && (I_PADDR == `OFS_CMP_A)),
        .i_load       (load_evt),
        .i_tick       (timer_tick),
        .i_block      (block_reg),
        .i_bottom_evt (bottom_evt),
        .i_force      (force_a),
        .i_clear      (I_ACK_CMP_A || (wr_en && (I_PADDR == `OFS_FLAG) && wdat[`BIT_CMP_A])),
        .o_active     (active_a),
        .o_buffer     (buffer_a),
        .o_match      (match_a),
        .o_flag       (compare_a_flag),
        .o_wave       (wave_a)
    );

    timer8_compare_unit u_cmp_b (
        .i_clk        (I_MCLK),
        .i_rst_n      (I_RSTN),
        .i_ctl        (ctl_b),
        .i_count      (count_value_reg),
        .i_wr_data    (wdat),
        .i_wr         (wr_en && (I_PADDR == `OFS_CMP_B)),
        .i_load       (load_evt),
        .i_tick       (timer_tick),
        .i_block      (block_reg),
        .i_bottom_evt (bottom_evt),
        .i_force      (force_b),
        .i_clear      (I_ACK_CMP_B || (wr_en && (I_PADDR == `OFS_FLAG) && wdat[`BIT_CMP_B])),
        .o_active     (active_b),
        .o_buffer     (buffer_b),
        .o_match      (match_b),
        .o_flag       (compare_b_flag),
        .o_wave       (wave_b)
    );

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_IRQ_OVF    <= 1'b0;
            O_IRQ_CMP_A  <= 1'b0;
            O_IRQ_CMP_B  <= 1'b0;
            O_WAVE_OUT_A <= 1'b0;
            O_WAVE_OUT_B <= 1'b0;
            O_WAVE_EN_A  <= 1'b0;
            O_WAVE_EN_B  <= 1'b0;
        end else begin
            O_IRQ_OVF    <= overflow_flag_reg && mask_reg[`BIT_OVF];
            O_IRQ_CMP_A  <= compare_a_flag && mask_reg[`BIT_CMP_A];
            O_IRQ_CMP_B  <= compare_b_flag && mask_reg[`BIT_CMP_B];
            O_WAVE_OUT_A <= wave_a;
            O_WAVE_OUT_B <= wave_b;
            O_WAVE_EN_A  <= control_a_reg[7:6] != `COM_NONE;
            O_WAVE_EN_B  <= control_a_reg[5:4] != `COM_NONE;
        end
    end

    // ========================================================
    // Assertions
    sequence cnt_write_s;
        cnt_wr;
    endsequence

    sequence tick_match_a_s;
        timer_tick && match_a && !block_reg;
    endsequence

    stop_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (clock_select == `CS_STOP) && !cnt_wr |=> $stable(count_value_reg))
        else $error("counter moved while stopped");

    write_prio_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        cnt_write_s |=> count_value_reg == $past(wdat))
        else $error("counter write lost");

    flag_set_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        tick_match_a_s |=> compare_a_flag)
        else $error("compare flag not set");

    match_block_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        cnt_write_s ##1 (!timer_tick && !compare_a_flag)[*1] ##1 timer_tick && !compare_a_flag
        |=> !compare_a_flag)
        else $error("blocked match set flag");

    ctc_clear_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        timer_tick && !cnt_wr && (waveform_mode == timer8_pkg::WM_CTC) && match_a
        |=> count_value_reg == `CNT_BOTTOM)
        else $error("ctc did not clear");

    force_clear_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        force_a && (control_a_reg[7:6] == `COM_CLEAR) |=> ##1 !O_WAVE_OUT_A)
        else $error("force clear ignored");

    ovf_normal_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        timer_tick && !cnt_wr && (waveform_mode == timer8_pkg::WM_NORMAL) && at_max
        |=> overflow_flag_reg && count_value_reg == `CNT_BOTTOM)
        else $error("overflow not flagged");

    irq_gate_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        (!mask_reg[`BIT_CMP_A])[*2] |-> !O_IRQ_CMP_A)
        else $error("masked request raised");

    buf_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        pwm && !load_evt ##1 pwm |-> $stable(active_a))
        else $error("buffer loaded off top");

    flag_set_b_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        timer_tick && match_b && !block_reg |=> compare_b_flag)
        else $error("compare b flag not set");

    direct_wr_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
        wr_en && (I_PADDR == `OFS_CMP_B) && !pwm |=> active_b == $past(wdat))
        else $error("compare write not direct");
endmodule : timer8_dual_compare_pwm
`default_nettype wire

// >>> tb/timer8_dual_compare_pwm_tb.sv
// Self-checking bench for the 8-bit dual compare timer, driven over APB.
// Assumes the design files are compiled first and a 20 MHz clock.
`default_nettype none
module timer8_dual_compare_pwm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0;
    logic        rstn = 0;
    logic        psel = 0;
    logic        pen = 0;
    logic        pwr = 0;
    logic        ext = 0;
    logic [2:0]  ack = '0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic        pready;
    logic        pslverr;
    logic        slverr;
    logic [2:0]  irq;
    logic [1:0]  wout;
    logic [1:0]  wen;
    int          err_count = 0;
    int          compares = 0;
    int          ones;
    // Control A value in [7:0], expected outputs and enables above it.
    // The sequence is set, no action, then clear on A and toggle on B.
    logic [11:0] ones_tab [3] = '{12'hff0, 12'h300, 12'hc90};

    always #25 clk = ~clk;

    timer8_dual_compare_pwm dut (.I_MCLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EXT_COUNT_INPUT(ext),
        .I_ACK_OVF(ack[0]), .I_ACK_CMP_A(ack[1]), .I_ACK_CMP_B(ack[2]), .O_IRQ_OVF(irq[0]),
        .O_IRQ_CMP_A(irq[1]), .O_IRQ_CMP_B(irq[2]), .O_WAVE_OUT_A(wout[0]),
        .O_WAVE_OUT_B(wout[1]), .O_WAVE_EN_A(wen[0]), .O_WAVE_EN_B(wen[1]));

    // ============================================================
    // Tasks
    task automatic give_verdict;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rd

    task automatic rng(input string nm, input int lo, input int hi, input logic [31:0] v);
        chk(nm, 32'h1, {31'h0, (v >= lo && v <= hi)});
    endtask : rng

    task automatic run(input logic [2:0] cs, input int n);
        wr(8'h04, {29'h0, cs});
        repeat (n) @(posedge clk);
        wr(8'h04, 32'h0);
    endtask : run

    // ============================================================
    // Scenarios
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0, "reset value");
        rd(8'h20, 32'h0, "unmapped data");
        chk("unmapped error", 32'h1, {31'h0, slverr});
        for (int a = 12; a < 24; a += 4) begin
            wr(a[7:0], 32'hffff_ff5a ^ a);
            rd(a[7:0], {24'h0, 8'h5a ^ 8'(a)}, "byte register");
        end
        repeat (20) @(posedge clk);
        rd(8'h0c, 32'h56, "stopped count");
        // overflow and compare flags, masked requests.
        wr(8'h10, 32'hf8);
        wr(8'h14, 32'h80);
        wr(8'h18, 32'h1);
        wr(8'h0c, 32'hf0);
        run(3'h1, 20);
        rd(8'h1c, 32'h3, "flags after wrap");
        chk("irq masked", 32'h1, {29'h0, irq});
        wr(8'h1c, 32'h2);
        ack[0] <= 1'b1;
        @(posedge clk);
        ack[0] <= 1'b0;
        rd(8'h1c, 32'h0, "flags cleared");
        chk("irq cleared", 32'h0, {29'h0, irq});
        // a counter write hides the match of the next tick.
        wr(8'h10, 32'h40);
        wr(8'h0c, 32'h40);
        run(3'h1, 4);
        rd(8'h1c, 32'h0, "blocked match");
        wr(8'h0c, 32'h3e);
        run(3'h1, 4);
        rd(8'h1c, 32'h2, "unblocked match");
        wr(8'h1c, 32'h7);
        wr(8'h0c, 32'h0);
        run(3'h2, 80);
        apb(1'b0, 8'h0c, 32'h0);
        rng("divide by 8 count", 9, 12, rdat);
        for (int cs = 6; cs < 8; cs++) begin
            wr(8'h0c, 32'h0);
            wr(8'h04, cs);
            repeat (10) begin
                ext <= ~ext;
                repeat (4) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            wr(8'h04, 32'h0);
            rd(8'h0c, 32'h5, "pin edge count");
        end
        foreach (ones_tab[i]) begin
            wr(8'h00, ones_tab[i][7:0]);
            wr(8'h08, 32'hc0);
            repeat (3) @(posedge clk);
            chk("forced wave", {30'h0, ones_tab[i][9:8]}, {30'h0, wout});
            chk("wave enable", {30'h0, ones_tab[i][11:10]}, {30'h0, wen});
            rd(8'h08, 32'h0, "force reads zero");
            rd(8'h1c, 32'h0, "force sets no flag");
        end
        wr(8'h10, 32'h5);
        wr(8'h00, 32'h2);
        wr(8'h0c, 32'h0);
        wr(8'h04, 32'h1);
        repeat (6) begin
            apb(1'b0, 8'h0c, 32'h0);
            rng("cleared count", 0, 5, rdat);
        end
        wr(8'h04, 32'h0);
        rd(8'h1c, 32'h2, "top match flag");
        // fast pulse width with clear on match, set at bottom.
        wr(8'h10, 32'h80);
        wr(8'h00, 32'h83);
        wr(8'h04, 32'h1);
        // The output is first set at bottom, so one whole period passes before sampling.
        repeat (300) @(posedge clk);
        ones = 0;
        repeat (512) @(posedge clk) ones += int'(wout[0] === 1'b1);
        wr(8'h04, 32'h0);
        rng("pulse high cycles", 250, 262, ones);
        give_verdict();
    end

    // The tests need about 1300 cycles; twenty thousand leaves ample margin.
    initial begin
        #(50 * 20000);
        err_count++;
        give_verdict();
    end
endmodule : timer8_dual_compare_pwm_tb
`default_nettype wire
